// ==== bpiu_top.sv ====
// Purpose: Interrupt unit: capture, mask, prioritise, vector and call request
// Assumes: Core strobes instruction boundary; core pushes stack and runs call
// Notes: Falling CPU clock sampling is modelled on core_clk rising edges
//
// How it works
// - Falling non-maskable pin edge latches pending request
// - Direction bit zero input, one output, resets zero
// - Output mode drives mask bit, mirror shows pin
// - Remote ack write toggles ext mask bit in output mode only; reads back mask
// - Four internal sources, receiver source selectable
// - Global enable gates maskables, never non-maskable
// - Global enable resets zero, software read/write
// - Exchange and return instructions alter global enable
// - Taking interrupt clears global enable
// - Five mask bits, one masks source
// - Mask bits reset to ones
// - Masked requests stay pending until unmasked
// - Fixed priority non-maskable, rx, txe, lta, ext, timeout
// - Vector is base, zeros, code, zeros
// - Source codes 111,001,010,011,100,101
// - Requests sampled every cycle; boundary decides
// - Taken call skips instruction; core stacks state
// - Two-state internal call branches to vector
`timescale 1ns/100ps
module bpiu_top
  import bpiu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Remote processor acknowledge write strobe
  input wire logic remote_ack_write,
  // Pins, active low; output enable active high
  input wire logic nmi_n,
  input wire logic shared_ext_request_n_in,
  output logic shared_ext_request_n_out,
  output logic shared_ext_request_n_oe,
  // Transceiver sources
  input wire bpiu_xcvr_irq_type xcvr_irq,
  // Core handshake
  input wire bpiu_core_ctl_type core_ctl,
  output bpiu_call_type call_q
);

  // Pin synchronisers
  logic [1:0] nmi_sync_q, nmi_sync_d;
  logic [1:0] ext_sync_q, ext_sync_d;
  logic nmi_prev_q, nmi_prev_d;
  logic nmi_pend_q, nmi_pend_d;
  // Registers
  logic [4:0] mask_q, mask_d;
  logic [1:0] rx_sel_q, rx_sel_d;
  logic gie_q, gie_d;
  logic dir_q, dir_d;
  logic [7:0] base_q, base_d;
  logic pin_mirror_q, pin_mirror_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic pin_out_q, pin_out_d;
  logic pin_oe_q, pin_oe_d;
  bpiu_call_type call_d;
  logic access;
  logic rx_req;
  logic [5:0] pend;
  logic [2:0] code;
  logic hit;

  function automatic logic [15:0] make_vector(input logic [7:0] base, input logic [2:0] c);
    make_vector = {base, 3'h0, c, 2'h0};
  endfunction : make_vector

  // Receiver source choice
  always_comb begin
    case (rx_sel_q)
      BPIU_RXSEL_FULL: rx_req = xcvr_irq.rx_fifo_full_irq;
      BPIU_RXSEL_AVAIL: rx_req = xcvr_irq.rx_data_avail_irq;
      BPIU_RXSEL_ACTIVE: rx_req = xcvr_irq.rx_active_irq;
      default: rx_req = 1'b0;
    endcase
  end

  // Priority resolve
  always_comb begin
    // Level requests stay visible while masked, taken once unmasked
    pend[0] = nmi_pend_q;
    pend[1] = gie_q & ~mask_q[0] & rx_req;
    pend[2] = gie_q & ~mask_q[1] & xcvr_irq.tx_fifo_empty_irq;
    pend[3] = gie_q & ~mask_q[2] & xcvr_irq.line_turnaround_irq;
    pend[4] = gie_q & ~mask_q[3] & ~ext_sync_q[1] & ~dir_q;
    pend[5] = gie_q & ~mask_q[4] & xcvr_irq.timeout_irq;
    hit = |pend;
    if (pend[0]) code = BPIU_CODE_NMI;
    else if (pend[1]) code = BPIU_CODE_RX;
    else if (pend[2]) code = BPIU_CODE_TXE;
    else if (pend[3]) code = BPIU_CODE_LTA;
    else if (pend[4]) code = BPIU_CODE_EXT;
    else code = BPIU_CODE_TO;
  end

  always_comb begin
    access = (avs_read | avs_write) & wait_q;
    nmi_sync_d = {nmi_sync_q[0], nmi_n};
    ext_sync_d = {ext_sync_q[0], shared_ext_request_n_in};
    nmi_prev_d = nmi_sync_q[1];
    nmi_pend_d = nmi_pend_q;
    mask_d = mask_q;
    rx_sel_d = rx_sel_q;
    gie_d = gie_q;
    dir_d = dir_q;
    base_d = base_q;
    rdata_d = rdata_q;
    wait_d = 1'b1;
    call_d = '0;
    // Update pin level and mirror once per instruction start
    pin_out_d = pin_out_q;
    pin_mirror_d = pin_mirror_q;
    if (core_ctl.boundary) begin
      pin_out_d = mask_q[3];
      pin_mirror_d = dir_q ? pin_out_q : ext_sync_q[1];
    end
    pin_oe_d = dir_q;
    // Software writes
    if (access && avs_write && avs_byteenable[0]) begin
      if (avs_address == BPIU_IRQ_CONTROL_OFF) begin
        mask_d = avs_writedata[BPIU_MASK_LSB +: 5];
        rx_sel_d = avs_writedata[BPIU_RXSEL_LSB +: 2];
      end else if (avs_address == BPIU_AUX_CONTROL_OFF) begin
        gie_d = avs_writedata[BPIU_GIE_BIT];
        dir_d = avs_writedata[BPIU_DIR_BIT];
      end else if (avs_address == BPIU_VECTOR_BASE_OFF) begin
        base_d = avs_writedata[7:0];
      end
    end
    // Remote ack toggles after any local write, so core write and ack both show
    if (remote_ack_write && dir_q) begin
      mask_d[BPIU_EXT_MASK_BIT] = ~mask_d[BPIU_EXT_MASK_BIT];
    end
    if (access) begin
      wait_d = 1'b0;
      rdata_d = 32'h0;
      if (avs_address == BPIU_IRQ_CONTROL_OFF) begin
        rdata_d[BPIU_MASK_LSB +: 5] = mask_q;
        rdata_d[BPIU_RXSEL_LSB +: 2] = rx_sel_q;
        rdata_d[BPIU_REMOTE_ACK_BIT] = mask_q[BPIU_EXT_MASK_BIT];
      end else if (avs_address == BPIU_AUX_CONTROL_OFF) begin
        rdata_d[BPIU_GIE_BIT] = gie_q;
        rdata_d[BPIU_DIR_BIT] = dir_q;
      end else if (avs_address == BPIU_VECTOR_BASE_OFF) begin
        rdata_d[7:0] = base_q;
      end else if (avs_address == BPIU_STATUS_OFF) begin
        rdata_d[0] = pin_mirror_q;
        rdata_d[1] = nmi_pend_q;
      end
    end
    // Instruction options on the enable
    if (core_ctl.exchange || core_ctl.ret) begin
      case (core_ctl.gie_op)
        BPIU_GIE_SET: gie_d = 1'b1;
        BPIU_GIE_CLEAR: gie_d = 1'b0;
        BPIU_GIE_RESTORE: gie_d = core_ctl.ret ? core_ctl.stacked_gie : gie_d;
        default: gie_d = gie_d;
      endcase
    end
    // Boundary decides; one call per boundary
    if (core_ctl.boundary && hit) begin
      call_d.take = 1'b1;
      call_d.vector = make_vector(base_q, code);
      call_d.saved_gie = gie_q;
      gie_d = 1'b0;
      if (pend[0]) nmi_pend_d = 1'b0;
    end
    // Falling pin edge after sync; set wins over a same-cycle clear
    if (nmi_prev_q && !nmi_sync_q[1]) nmi_pend_d = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nmi_sync_q <= 2'h3;
      ext_sync_q <= 2'h3;
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
      mask_q <= BPIU_MASK_RESET;
      rx_sel_q <= 2'h0;
      gie_q <= 1'b0;
      dir_q <= 1'b0;
      base_q <= BPIU_BASE_RESET;
      pin_mirror_q <= 1'b1;
      rdata_q <= 32'h0;
      wait_q <= 1'b1;
      pin_out_q <= 1'b1;
      pin_oe_q <= 1'b0;
      call_q <= '0;
    end else begin
      nmi_sync_q <= nmi_sync_d;
      ext_sync_q <= ext_sync_d;
      nmi_prev_q <= nmi_prev_d;
      nmi_pend_q <= nmi_pend_d;
      mask_q <= mask_d;
      rx_sel_q <= rx_sel_d;
      gie_q <= gie_d;
      dir_q <= dir_d;
      base_q <= base_d;
      pin_mirror_q <= pin_mirror_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      call_q <= call_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign shared_ext_request_n_out = pin_out_q;
  assign shared_ext_request_n_oe = pin_oe_q;

endmodule : bpiu_top

// ==== bpiu_pkg.sv ====
// Purpose: Shared constants and types for the biphase processor interrupt unit
// Assumes: Avalon-MM register access, 32-bit data, word-aligned byte addresses
// Notes: Register offsets are byte addresses
package bpiu_pkg;

  // Register byte offsets
  localparam logic [3:0] BPIU_IRQ_CONTROL_OFF = 4'h0;
  localparam logic [3:0] BPIU_AUX_CONTROL_OFF = 4'h4;
  localparam logic [3:0] BPIU_VECTOR_BASE_OFF = 4'h8;
  localparam logic [3:0] BPIU_STATUS_OFF = 4'hC;

  // irq_control_reg fields
  localparam int BPIU_MASK_LSB = 0;
  localparam int BPIU_EXT_MASK_BIT = 3;
  localparam int BPIU_RXSEL_LSB = 5;
  localparam int BPIU_REMOTE_ACK_BIT = 7;
  // aux_control_reg fields
  localparam int BPIU_GIE_BIT = 0;
  localparam int BPIU_DIR_BIT = 1;

  localparam logic [4:0] BPIU_MASK_RESET = 5'h1F;
  localparam logic [7:0] BPIU_BASE_RESET = 8'h00;

  // Source codes for vector bits 4..2
  localparam logic [2:0] BPIU_CODE_NMI = 3'h7;
  localparam logic [2:0] BPIU_CODE_RX = 3'h1;
  localparam logic [2:0] BPIU_CODE_TXE = 3'h2;
  localparam logic [2:0] BPIU_CODE_LTA = 3'h3;
  localparam logic [2:0] BPIU_CODE_EXT = 3'h4;
  localparam logic [2:0] BPIU_CODE_TO = 3'h5;

  // Receiver source select
  localparam logic [1:0] BPIU_RXSEL_FULL = 2'h0;
  localparam logic [1:0] BPIU_RXSEL_AVAIL = 2'h1;
  localparam logic [1:0] BPIU_RXSEL_ACTIVE = 2'h2;

  // Enable-change options for exchange / return instructions
  typedef enum logic [1:0] {
    BPIU_GIE_KEEP,
    BPIU_GIE_SET,
    BPIU_GIE_CLEAR,
    BPIU_GIE_RESTORE
  } bpiu_gie_op_type;

  typedef struct packed {
    logic tx_fifo_empty_irq;
    logic line_turnaround_irq;
    logic timeout_irq;
    logic rx_fifo_full_irq;
    logic rx_data_avail_irq;
    logic rx_active_irq;
  } bpiu_xcvr_irq_type;

  // Core-side handshake: boundary strobe and option fields
  typedef struct packed {
    logic boundary;
    logic exchange;
    logic ret;
    bpiu_gie_op_type gie_op;
    logic stacked_gie;
  } bpiu_core_ctl_type;

  typedef struct packed {
    logic take;
    logic [15:0] vector;
    logic saved_gie;
  } bpiu_call_type;

endpackage : bpiu_pkg

// ==== bpiu_top_checker.sv ====
// Purpose: Port checks for the interrupt unit
// Assumes: Single clock, sync reset
// Notes: Bound to bpiu_top below
`timescale 1ns/100ps
module bpiu_top_checker
  import bpiu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Observed ports
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic shared_ext_request_n_out,
  input wire bpiu_core_ctl_type core_ctl,
  input wire bpiu_call_type call_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_TAKE_ONE: assert property (call_q.take |=> !call_q.take)
    else $error("call pulse too long");
  AST_TAKE_CAUSE: assert property (call_q.take |-> $past(core_ctl.boundary))
    else $error("call without boundary");
  AST_VEC_ZEROS: assert property (call_q.take |-> !call_q.vector[7:5] && !call_q.vector[1:0])
    else $error("vector zero fields set");
  AST_VEC_CODE: assert property (call_q.take |-> call_q.vector[4:2] inside {1, 2, 3, 4, 5, 7})
    else $error("illegal source code");
  AST_GIE_GATE: assert property (call_q.take && call_q.vector[4:2] != 3'h7 |-> call_q.saved_gie)
    else $error("maskable taken with enable low");
  AST_PIN_HOLD: assert property (!$past(core_ctl.boundary) |-> $stable(shared_ext_request_n_out))
    else $error("pin moved off boundary");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_WAIT_BACK: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
endmodule : bpiu_top_checker
bind bpiu_top bpiu_top_checker bpiu_top_checker_i (.core_clk, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .shared_ext_request_n_out, .core_ctl, .call_q);

// ==== bpiu_remote_model.sv ====
// Purpose: Remote host side of the shared request line
// Assumes: Bench tells it when to request and acknowledge
// Notes: Line has a pull-up
`timescale 1ns/100ps
module bpiu_remote_model (
  // Bench commands
  input wire logic hold_req,
  input wire logic ack_req,
  // Line
  input wire logic pin_out_n,
  input wire logic pin_oe,
  output logic pin_n,
  output logic ack_pulse
);
  // Released line floats up, never keeps the old low
  assign pin_n = pin_oe ? pin_out_n : !hold_req;
  assign ack_pulse = ack_req;
endmodule : bpiu_remote_model

// ==== tb_bpiu_top.sv ====
// Purpose: Self-checking bench for the interrupt unit
// Assumes: Bus and call timing as handed over
// Notes: Byte enable tied on
`timescale 1ns/100ps
module tb_bpiu_top;
  import bpiu_pkg::*;
  logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest, nmi_n;
  logic pin_n, pin_out, pin_oe, hold_req, ack_req, ack_pulse;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  bpiu_xcvr_irq_type xcvr;
  bpiu_core_ctl_type ctl;
  bpiu_call_type call;
  int mismatches, checked;
  // Source pattern, receiver select, code
  logic [10:0] tbl [6] = '{11'h081, 11'h049, 11'h031, 11'h402, 11'h203, 11'h105};
  bpiu_top bpiu_top_i (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .remote_ack_write(ack_pulse), .nmi_n, .shared_ext_request_n_in(pin_n),
    .shared_ext_request_n_out(pin_out), .shared_ext_request_n_oe(pin_oe),
    .xcvr_irq(xcvr), .core_ctl(ctl), .call_q(call));
  bpiu_remote_model bpiu_remote_model_i (.hold_req, .ack_req, .pin_out_n(pin_out),
    .pin_oe, .pin_n, .ack_pulse);
  function automatic logic [16:0] vec(input logic [2:0] code);
    return {1'h1, 8'hA5, 3'h0, code, 2'h0};
  endfunction : vec
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // Edge pause after release avoids re-raising in one step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge core_clk iff !avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask : bus
  task automatic bnd(input logic [5:0] c, input logic [16:0] exp);
    ctl <= c;
    @(posedge core_clk);
    ctl <= '0;
    // Take stands one cycle; look mid-cycle once it has settled
    @(negedge core_clk);
    cmp(32'({call.take, call.vector}), 32'(exp));
    @(posedge core_clk);
  endtask : bnd
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = !core_clk;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end
  initial begin
    {avs_read, avs_write, hold_req, ack_req, avs_address, avs_writedata, xcvr, ctl} = '0;
    nmi_n = 1'h1;
    sys_rst = 1'h1;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'h0;
    bus(1'h0, BPIU_IRQ_CONTROL_OFF, 32'h0);
    cmp(rd, 32'h9F);
    bus(1'h0, BPIU_AUX_CONTROL_OFF, 32'h0);
    cmp(rd, 32'h0);
    bus(1'h0, 4'h2, 32'h0);
    cmp(rd, 32'h0);
    bus(1'h1, BPIU_VECTOR_BASE_OFF, 32'hA5);
    bus(1'h1, BPIU_IRQ_CONTROL_OFF, 32'h20);
    xcvr <= 6'h3F;
    bus(1'h1, BPIU_AUX_CONTROL_OFF, 32'h1);
    bnd(6'h20, vec(BPIU_CODE_RX));
    bus(1'h0, BPIU_AUX_CONTROL_OFF, 32'h0);
    cmp(rd, 32'h0);
    foreach (tbl[i]) begin
      xcvr <= tbl[i][10:5];
      bus(1'h1, BPIU_IRQ_CONTROL_OFF, {25'h0, tbl[i][4:3], 5'h0});
      bus(1'h1, BPIU_AUX_CONTROL_OFF, 32'h1);
      bnd(6'h20, vec(tbl[i][2:0]));
    end
    xcvr <= 6'h08;
    hold_req <= 1'h1;
    bus(1'h1, BPIU_AUX_CONTROL_OFF, 32'h1);
    bnd(6'h20, vec(BPIU_CODE_EXT));
    hold_req <= 1'h0;
    xcvr <= 6'h20;
    bus(1'h1, BPIU_IRQ_CONTROL_OFF, 32'h2);
    bus(1'h1, BPIU_AUX_CONTROL_OFF, 32'h1);
    bnd(6'h20, 17'h0);
    bus(1'h1, BPIU_IRQ_CONTROL_OFF, 32'h0);
    bnd(6'h20, vec(BPIU_CODE_TXE));
    bnd(6'h20, 17'h0);
    nmi_n <= 1'h0;
    repeat (4) @(posedge core_clk);
    bnd(6'h20, vec(BPIU_CODE_NMI));
    xcvr <= '0;
    bnd(6'h20, 17'h0);
    nmi_n <= 1'h1;
    bnd(6'h12, 17'h0);
    bus(1'h0, BPIU_AUX_CONTROL_OFF, 32'h0);
    cmp(rd, 32'h1);
    bnd(6'h0E, 17'h0);
    bus(1'h0, BPIU_AUX_CONTROL_OFF, 32'h0);
    cmp(rd, 32'h0);
    bus(1'h1, BPIU_IRQ_CONTROL_OFF, 32'h1F);
    bus(1'h1, BPIU_AUX_CONTROL_OFF, 32'h2);
    bnd(6'h20, 17'h0);
    cmp({30'h0, pin_oe, pin_out}, 32'h3);
    ack_req <= 1'h1;
    @(posedge core_clk);
    ack_req <= 1'h0;
    bus(1'h0, BPIU_IRQ_CONTROL_OFF, 32'h0);
    cmp(rd, 32'h17);
    bnd(6'h20, 17'h0);
    cmp({30'h0, pin_oe, pin_out}, 32'h2);
    bnd(6'h20, 17'h0);
    bus(1'h0, BPIU_STATUS_OFF, 32'h0);
    cmp(rd, 32'h0);
    finish_test();
  end
endmodule : tb_bpiu_top
